// ===== bicr_cfg_regs.sv
// How it works
// - Fixed read-only maker code, low half word zero
// - Part code loaded at reset, upper half
// - Bit 0 enables primary I/O response
// - Bit 1 enables primary memory response
// - Bit 2 clear: no mastering, no secondary response
// - Bit 2 set: master forwarded secondary transactions
// - Special-cycle bit reads zero, read-only
// - Invalidate bit zero; forward only others' invalidates
// - Bit 5 claims palette writes, low ten bits
// - Bit 6 gates parity error actions
// - Stepping bit reads zero, read-only
// - Bit 8 gates system-error output driver
// - Bit 9 permits fast back-to-back mastering
// - Bits 15:10 reserved, read zero
// - Reached by primary configuration cycles at fixed offsets
`timescale 1ns/10ps
`default_nettype none

// Included ahead of the header so the parameter defaults can see the macros
`include "bicr_regs.svh"

module bicr_cfg_regs
  import bicr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = `BICR_MAKER_ID_DEF,
  parameter logic [15:0] PART_ID  = `BICR_PART_ID_DEF
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration access, primary side
  input  wire logic        cfg_sel,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be_n,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rdata_valid,
  // Primary target decode
  input  wire logic        io_decode_hit,
  input  wire logic        mem_decode_hit,
  output logic             io_claim,
  output logic             mem_claim,
  input  wire logic        io_write_cyc,
  input  wire bicr_pkg::bicr_io_addr_t io_addr,
  output logic             palette_claim,
  // Mastering and secondary response
  input  wire logic        sec_fwd_req,
  output logic             primary_master_go,
  input  wire logic        sec_decode_hit,
  output logic             sec_claim,
  input  wire logic        fwd_mwi,
  output logic             mwi_issue,
  input  wire logic        fb2b_req,
  output logic             fb2b_go,
  // Error handling
  input  wire logic        parity_err_det,
  output logic             parity_err_act,
  input  wire logic        serr_req,
  output logic             primary_system_error_out,
  output logic             primary_system_error_oe
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Dword indices sized to match cfg_addr[7:2], so compares stay 6 bits wide
  localparam logic [5:0]  IDENT_DW   = 6'(`BICR_OFF_IDENT >> 2);
  localparam logic [5:0]  COMMAND_DW = 6'(`BICR_OFF_COMMAND >> 2);
  // A literal cannot be part-selected, so the mask lives in a named constant
  localparam logic [15:0] WR_MASK    = `BICR_CMD_WR_MASK;

  bicr_state_t state_reg;
  bicr_state_t state_next;
  logic        rd_hit;
  logic        wr_cmd;
  logic [15:0] cmd;

  assign rd_hit = cfg_sel && !cfg_write;
  assign wr_cmd = cfg_sel && cfg_write &&
                  (cfg_addr[7:2] == COMMAND_DW);
  assign cmd    = state_reg.cmd_reg;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Read data is captured one cycle after the request
  always_comb
  begin
    state_next            = state_reg;
    state_next.rvalid_reg = rd_hit;
    if (wr_cmd)
    begin
      // Each lane writes only its writable bits; fixed bits stay zero
      for (int b = 0; b < 2; b++)
      begin
        if (!cfg_be_n[b])
        begin
          state_next.cmd_reg[b*8 +: 8] =
            cfg_wdata[b*8 +: 8] & WR_MASK[b*8 +: 8];
        end
      end
    end
    if (rd_hit)
    begin
      case (cfg_addr[7:2])
        IDENT_DW:
          state_next.rdata_reg = {state_reg.part_id_reg, MAKER_ID};
        COMMAND_DW:
          // Status half lives elsewhere and reads zero here
          state_next.rdata_reg = {16'h0000,
                                  state_reg.cmd_reg & WR_MASK};
        default:
          state_next.rdata_reg = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Part code is a reset-time load, so it never follows a write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg.cmd_reg     <= `BICR_CMD_RESET;
      state_reg.part_id_reg <= PART_ID;
      state_reg.rdata_reg   <= 32'h0000_0000;
      state_reg.rvalid_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign cfg_rdata       = state_reg.rdata_reg;
  assign cfg_rdata_valid = state_reg.rvalid_reg;

  // ----------------------------------------------------------------
  // Gating of bridge behaviour
  // ----------------------------------------------------------------
  assign io_claim          = io_decode_hit  && cmd[`BICR_CMD_IO_EN];
  assign mem_claim         = mem_decode_hit && cmd[`BICR_CMD_MEM_EN];
  assign primary_master_go = sec_fwd_req    && cmd[`BICR_CMD_MASTER_EN];
  assign sec_claim         = sec_decode_hit && cmd[`BICR_CMD_MASTER_EN];
  // Invalidate commands pass only when another master started them
  assign mwi_issue         = fwd_mwi && primary_master_go;
  assign fb2b_go           = fb2b_req && cmd[`BICR_CMD_FB2B_EN];
  assign parity_err_act    = parity_err_det && cmd[`BICR_CMD_PARITY_EN];
  // Open-drain: only ever pulls low, enable carries the assertion
  assign primary_system_error_out = 1'b0;
  assign primary_system_error_oe  = serr_req && cmd[`BICR_CMD_SYSERR_EN];

  // Palette snoop decoding
  bicr_palette_decode u_palette (
    .snoop_en     (cmd[`BICR_CMD_SNOOP_EN]),
    .io_write_cyc (io_write_cyc),
    .io_addr      (io_addr),
    .palette_hit  (palette_claim)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_maker_code_fixed: assert property (
    rd_hit && cfg_addr[7:2] == IDENT_DW |=> cfg_rdata[15:0] == MAKER_ID && cfg_rdata_valid)
    else $error("maker code wrong");
  a_part_code_fixed: assert property (
    rd_hit && cfg_addr[7:2] == IDENT_DW |=> cfg_rdata[31:16] == PART_ID)
    else $error("part code wrong");
  a_io_enable_set: assert property (
    wr_cmd && !cfg_be_n[0] && cfg_wdata[0] ##1 io_decode_hit |-> io_claim)
    else $error("io enable not taken");
  a_io_gate_off: assert property (
    !cmd[0] |-> !io_claim)
    else $error("io claimed while off");
  a_mem_gate_off: assert property (
    !cmd[1] && mem_decode_hit |-> !mem_claim)
    else $error("memory claimed while off");
  a_master_pair_off: assert property (
    !cmd[2] |-> !primary_master_go && !sec_claim)
    else $error("master or secondary active while off");
  a_master_write_on: assert property (
    wr_cmd && !cfg_be_n[0] && cfg_wdata[2] ##1 sec_fwd_req |-> primary_master_go)
    else $error("master enable not taken");
  a_fixed_bits_zero: assert property (
    rd_hit && cfg_addr[7:2] == COMMAND_DW |=>
      cfg_rdata[3] == 1'b0 && cfg_rdata[4] == 1'b0 && cfg_rdata[7] == 1'b0 &&
      cfg_rdata[15:10] == 6'h00)
    else $error("fixed command bits not zero");
  a_mwi_only_forward: assert property (
    mwi_issue |-> fwd_mwi && cmd[2])
    else $error("invalidate not forwarded");
  a_palette_decode: assert property (
    cmd[5] && io_write_cyc && io_addr == 10'h3C8 |-> palette_claim)
    else $error("palette write missed");
  a_snoop_gate_off: assert property (
    !cmd[5] |-> !palette_claim)
    else $error("palette claimed while off");
  a_parity_gate: assert property (
    parity_err_act |-> parity_err_det && cmd[6])
    else $error("parity action while off");
  a_syserr_gate: assert property (
    !cmd[8] |-> !primary_system_error_oe)
    else $error("system error driven while off");
  a_fb2b_clear: assert property (
    wr_cmd && !cfg_be_n[1] && !cfg_wdata[9] |=> !fb2b_go)
    else $error("fast back-to-back after clear");
  a_read_valid_pulse: assert property (
    !rd_hit |=> !cfg_rdata_valid)
    else $error("read valid without a read");
  a_lane_masked: assert property (
    wr_cmd && cfg_be_n[0] |=> cmd[7:0] == $past(cmd[7:0]))
    else $error("disabled lane written");
  a_lane_hi_masked: assert property (
    wr_cmd && cfg_be_n[1] |=> cmd[15:8] == $past(cmd[15:8]))
    else $error("disabled upper lane written");

endmodule // bicr_cfg_regs

`default_nettype wire

// ===== bicr_regs.svh
`ifndef BICR_REGS_SVH
`define BICR_REGS_SVH

// ----------------------------------------------------------------
// Configuration header offsets (byte addresses)
// ----------------------------------------------------------------
`define BICR_OFF_IDENT      8'h00
`define BICR_OFF_COMMAND    8'h04

// ----------------------------------------------------------------
// Identification field positions
// ----------------------------------------------------------------
`define BICR_MAKER_LSB      0
`define BICR_PART_LSB       16
// Arbitrary neutral identification values
`define BICR_MAKER_ID_DEF   16'h1AB0
`define BICR_PART_ID_DEF    16'h0B1C

// ----------------------------------------------------------------
// Command field positions
// ----------------------------------------------------------------
`define BICR_CMD_IO_EN      0
`define BICR_CMD_MEM_EN     1
`define BICR_CMD_MASTER_EN  2
`define BICR_CMD_SPECIAL    3
`define BICR_CMD_MWI        4
`define BICR_CMD_SNOOP_EN   5
`define BICR_CMD_PARITY_EN  6
`define BICR_CMD_STEPPING   7
`define BICR_CMD_SYSERR_EN  8
`define BICR_CMD_FB2B_EN    9

// Writable bits 0,1,2,5,6,8,9; all else reads zero
`define BICR_CMD_WR_MASK    16'h0367
`define BICR_CMD_RESET      16'h0000

// ----------------------------------------------------------------
// Palette snoop I/O addresses (low ten bits only)
// ----------------------------------------------------------------
`define BICR_PAL_MASK_ADDR  10'h3C6
`define BICR_PAL_WIDX_ADDR  10'h3C8
`define BICR_PAL_DATA_ADDR  10'h3C9

`endif

// ===== bicr_pkg.sv
package bicr_pkg;

  // Whole state of the register bank
  typedef struct packed {
    logic [15:0] cmd_reg;
    logic [15:0] part_id_reg;
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
  } bicr_state_t;

  typedef logic [9:0] bicr_io_addr_t;

endpackage : bicr_pkg

// ===== bicr_palette_decode.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Palette write snoop decoder
// ----------------------------------------------------------------
module bicr_palette_decode
  import bicr_pkg::*;
(
  input  wire logic            snoop_en,
  input  wire logic            io_write_cyc,
  input  wire bicr_pkg::bicr_io_addr_t io_addr,
  output logic                 palette_hit
);

`include "bicr_regs.svh"

  // Upper bits 15:10 are aliases, so only the low ten bits arrive here
  assign palette_hit = snoop_en && io_write_cyc &&
                       ((io_addr == `BICR_PAL_MASK_ADDR) ||
                        (io_addr == `BICR_PAL_WIDX_ADDR) ||
                        (io_addr == `BICR_PAL_DATA_ADDR));

endmodule // bicr_palette_decode

`default_nettype wire

// ===== bicr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Configuration host on the primary side
// ----------------------------------------
module bicr_host_model
(
  input  wire logic        clk,
  output logic             cfg_sel,
  output logic             cfg_write,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be_n,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rdata_valid
);
  // Idle bus before the first access
  initial
  begin
    cfg_sel = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_be_n = 4'hF;
    cfg_wdata = 32'h0;
  end

  // One config cycle, held over one rising edge
  task automatic cyc(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_sel = 1'b1;
    cfg_write = w;
    cfg_addr = a;
    cfg_be_n = be;
    cfg_wdata = d;
    @(negedge clk);
    cfg_sel = 1'b0;
    cfg_wdata = ~d; // Released bus shows no stale data
  endtask

  // Read data lands one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic v);
    cyc(1'b0, a, 4'h0, 32'h0);
    d = cfg_rdata;
    v = cfg_rdata_valid;
  endtask
endmodule // bicr_host_model

`default_nettype wire

// ===== bridge_id_and_command_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Bench for the identity and command bank
// ----------------------------------------
module bridge_id_and_command_regs_tb;
  import bicr_pkg::*;
  localparam logic [15:0] MK = 16'h5A3C; // Arbitrary
  localparam logic [15:0] PT = 16'hC3A5; // Arbitrary
  localparam logic [15:0] WM = 16'h0367;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_sel, cfg_write, cfg_rdata_valid, v;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be_n;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic io_decode_hit, mem_decode_hit, io_write_cyc, sec_fwd_req, sec_decode_hit;
  logic fwd_mwi, fb2b_req, parity_err_det, serr_req;
  logic io_claim, mem_claim, palette_claim, primary_master_go, sec_claim;
  logic mwi_issue, fb2b_go, parity_err_act;
  logic primary_system_error_out, primary_system_error_oe;
  bicr_io_addr_t io_addr;
  logic [9:0] outs;
  int fail_count = 0;
  int compares = 0;
  // Command value beside gate outputs with every request high
  logic [25:0] rows [9] = '{{16'h0001, 10'h200}, {16'h0002, 10'h100},
    {16'h0004, 10'h070}, {16'h0020, 10'h080}, {16'h0040, 10'h004},
    {16'h0100, 10'h002}, {16'h0200, 10'h008}, {16'hFFFF, 10'h3FE},
    {16'hFC98, 10'h000}};
  logic [9:0] pal [4] = '{10'h3C8, 10'h3C9, 10'h3C7, 10'h2C6};

`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
    end \
  end

  assign outs = {io_claim, mem_claim, palette_claim, primary_master_go, sec_claim,
    mwi_issue, fb2b_go, parity_err_act, primary_system_error_oe,
    primary_system_error_out};

  always #5 clk = ~clk;

  bicr_cfg_regs #(.MAKER_ID(MK), .PART_ID(PT)) i_bicr_cfg_regs (.clk, .rst_n,
    .cfg_sel, .cfg_write, .cfg_addr, .cfg_be_n, .cfg_wdata, .cfg_rdata,
    .cfg_rdata_valid, .io_decode_hit, .mem_decode_hit, .io_claim, .mem_claim,
    .io_write_cyc, .io_addr, .palette_claim, .sec_fwd_req, .primary_master_go,
    .sec_decode_hit, .sec_claim, .fwd_mwi, .mwi_issue, .fb2b_req, .fb2b_go,
    .parity_err_det, .parity_err_act, .serr_req, .primary_system_error_out,
    .primary_system_error_oe);

  bicr_host_model i_bicr_host_model (.clk, .cfg_sel, .cfg_write, .cfg_addr,
    .cfg_be_n, .cfg_wdata, .cfg_rdata, .cfg_rdata_valid);

  // Requests toward the gates, driven off the sampling edge
  task automatic set_in(input logic [8:0] r, input logic [9:0] a);
    {io_decode_hit, mem_decode_hit, io_write_cyc, sec_fwd_req, sec_decode_hit,
     fwd_mwi, fb2b_req, parity_err_det, serr_req} = r;
    io_addr = a;
  endtask

  task automatic wr(input logic [3:0] be, input logic [15:0] c);
    i_bicr_host_model.cyc(1'b1, 8'h04, be, {16'h0, c});
  endtask

  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 73 cycles needed
  initial
  begin
    #50000;
    fail_count++;
    close_out();
  end

  // Main sequence
  initial
  begin
    set_in(9'h1FF, 10'h3C6);
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    i_bicr_host_model.rd(8'h00, d, v);
    `CHK("ident", {PT, MK}, d)
    `CHK("valid", 1'b1, v)
    `CHK("reset gates", 10'h000, outs)
    i_bicr_host_model.cyc(1'b1, 8'h00, 4'h0, 32'hFFFFFFFF);
    i_bicr_host_model.rd(8'h00, d, v);
    `CHK("ident ro", {PT, MK}, d)
    foreach (rows[k])
    begin
      wr(4'hC, rows[k][25:10]);
      `CHK("gates", rows[k][9:0], outs)
      i_bicr_host_model.rd(8'h04, d, v);
      `CHK("cmd", {16'h0, rows[k][25:10] & WM}, d)
    end
    // Byte lanes touched one at a time
    wr(4'hE, 16'hFFFF);
    i_bicr_host_model.rd(8'h04, d, v);
    `CHK("lane0", 32'h0067, d)
    wr(4'hD, 16'hFFFF);
    wr(4'hE, 16'h0000);
    i_bicr_host_model.rd(8'h04, d, v);
    `CHK("lane1", 32'h0300, d)
    // Palette addresses and near misses, one falling edge apart
    wr(4'hC, 16'h0020);
    foreach (pal[k])
    begin
      set_in(9'h1FF, pal[k]);
      @(negedge clk);
      `CHK("palette", (k < 2) ? 1'b1 : 1'b0, palette_claim)
    end
    set_in(9'h000, 10'h3C6);
    wr(4'hC, 16'hFFFF);
    `CHK("idle gates", 10'h000, outs)
    i_bicr_host_model.rd(8'h08, d, v);
    `CHK("unmapped", 32'h0, d)
    `CHK("unmapped valid", 1'b1, v)
    // Reset in mid-run clears the command bits and the read path
    set_in(9'h1FF, 10'h3C6);
    i_bicr_host_model.rd(8'h04, d, v);
    `CHK("cmd all", 32'h0367, d)
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("rst rdata", 32'h0, cfg_rdata)
    `CHK("rst valid", 1'b0, cfg_rdata_valid)
    `CHK("rst gates", 10'h000, outs)
    rst_n = 1'b1;
    i_bicr_host_model.rd(8'h04, d, v);
    `CHK("rerst", 32'h0, d)
    close_out();
  end
endmodule // bridge_id_and_command_regs_tb

`default_nettype wire
